// [shared/rsqr_pkg.sv]
// constants and carriers for the radio status query responder
`default_nettype none
package rsqr_pkg;
  // ==========================================================
  // command opcodes and frame lengths in bytes, opcode counted
  localparam logic [7:0] OP_CHIP_STATE = 8'hc0;
  localparam logic [7:0] OP_RX_BUF = 8'h13;
  localparam logic [7:0] OP_PKT_QUAL = 8'h14;
  localparam logic [7:0] OP_INST_LEVEL = 8'h15;
  localparam logic [7:0] OP_CNT_QUERY = 8'h10;
  localparam logic [7:0] OP_CNT_CLEAR = 8'h00;
  localparam logic [3:0] LEN_CHIP_STATE = 4'h2;
  localparam logic [3:0] LEN_RX_BUF = 4'h4;
  localparam logic [3:0] LEN_PKT_QUAL = 4'h5;
  localparam logic [3:0] LEN_INST_LEVEL = 4'h3;
  localparam logic [3:0] LEN_CNT_QUERY = 4'h8;
  localparam logic [3:0] LEN_CNT_CLEAR = 4'h7;
  localparam logic [3:0] IDX_MAX = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;
  // ==========================================================
  // status byte fields and codes
  localparam int ST_MODE_LO = 4;
  localparam int ST_RES_LO = 1;
  localparam logic [2:0] MODE_UNUSED = 3'h0;
  localparam logic [2:0] MODE_STANDBY_RC_OSC_MODE = 3'h2;
  localparam logic [2:0] MODE_STBY_XTAL = 3'h3;
  localparam logic [2:0] MODE_SYNTH = 3'h4;
  localparam logic [2:0] MODE_RX = 3'h5;
  localparam logic [2:0] MODE_TX = 3'h6;
  localparam logic [2:0] RES_NONE = 3'h0;
  localparam logic [2:0] RES_DATA_AVAIL = 3'h2;
  localparam logic [2:0] RES_TIMEOUT = 3'h3;
  localparam logic [2:0] RES_PROC_ERR = 3'h4;
  localparam logic [2:0] RES_EXEC_FAIL = 3'h5;
  localparam logic [2:0] RES_TX_DONE = 3'h6;
  // ==========================================================
  // register map and watchdog timing
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_COUNT = 8'h08;
  localparam int CTRL_WDT_EN = 0;
  localparam logic CTRL_WDT_EN_RST = 1'b1;
  localparam int WDT_TIME_US = 1000;
  localparam int CLK_MHZ = 100;
  localparam int WDT_CYCLES = WDT_TIME_US * CLK_MHZ;
  // ==========================================================
  // carriers from the modem and packet handler
  typedef struct packed {
    logic [7:0] receive_flags;
    logic [7:0] payload_mean_level;
    logic [7:0] packet_mean_level;
    logic [7:0] packet_noise_ratio;
    logic [7:0] despread_signal_level;
    logic [7:0] instant_level;
    logic [7:0] received_length;
    logic [7:0] received_start_offset;
  } rsqr_meas_s;
  typedef struct packed {
    logic sync_det;
    logic pkt_done;
    logic rx_ok;
    logic checksum_fail;
    logic length_fail;
    logic header_fail;
    logic tx_done;
    logic exec_fail;
  } rsqr_evt_s;
  typedef enum logic {SPI_IDLE, SPI_XFER} rsqr_spi_e;
endpackage
`default_nettype wire

// [design/rsqr_responder.sv]
// status query responder: spi command port, status byte, counters, apb control
// ==========================================================
//
// The register addresses and the APB register port are this design's own decisions.
`default_nettype none
module rsqr_responder
  import rsqr_pkg::*;
#(
  parameter int unsigned WDT_LIMIT = WDT_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  input wire logic [2:0] chip_mode,
  input wire logic chirp_mode,
  input wire logic other_opcode_ok,
  input wire rsqr_meas_s meas,
  input wire rsqr_evt_s evt,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ==========================================================
  // pin synchronisers: [0] sck, [1] select, [2] data
  logic [2:0] pin_s1, pin_s2, pin_s3;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // idle pin levels: select high, sck low, so no false edge follows reset
      pin_s1 <= 3'h2;
      pin_s2 <= 3'h2;
      pin_s3 <= 3'h2;
    end else begin
      pin_s1 <= {mosi, chip_select_n, sck};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  logic sck_rise, sck_fall, cs_fall, cs_rise, mosi_s;
  assign sck_rise = pin_s2[0] & ~pin_s3[0];
  assign sck_fall = ~pin_s2[0] & pin_s3[0];
  assign cs_fall = ~pin_s2[1] & pin_s3[1];
  assign cs_rise = pin_s2[1] & ~pin_s3[1];
  assign mosi_s = pin_s2[2];

  // ==========================================================
  // status byte
  logic [2:0] outcome;
  logic [7:0] status_byte;
  logic wdt_en;
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_MODE_LO +: 3] = chip_mode;
    status_byte[ST_RES_LO +: 3] = outcome;
  end

  // ==========================================================
  // latched measurements and packet counters
  logic [7:0] sync_level, payload_level, flags, pkt_level, noise, despread;
  logic [7:0] rx_len, rx_off;
  logic [15:0] rcv_cnt, crc_cnt, err_cnt;

  // ==========================================================
  // spi frame engine
  rsqr_spi_e state, next_state;
  logic [2:0] bitc, next_bitc;
  logic [3:0] idx, next_idx;
  logic [7:0] rx_sh, next_rx_sh, opcode, next_opcode, tx_sh, next_tx_sh;
  logic [7:0] resp;
  logic next_miso, all_zero, next_all_zero;
  logic [31:0] wdt, next_wdt;
  logic wdt_hit, next_wdt_hit, perr, next_perr, clr, next_clr;
  logic [7:0] rx_byte;
  logic own_ok;

  // reply byte for position idx of the current frame
  always_comb begin
    resp = status_byte;
    unique case (opcode)
      OP_RX_BUF: begin
        if (idx == 4'h2) resp = rx_len;
        if (idx == 4'h3) resp = rx_off;
      end
      OP_PKT_QUAL: begin
        if (idx == 4'h2) resp = chirp_mode ? pkt_level : flags;
        if (idx == 4'h3) resp = chirp_mode ? noise : sync_level;
        if (idx == 4'h4) resp = chirp_mode ? despread : payload_level;
      end
      OP_INST_LEVEL: begin
        if (idx == 4'h2) resp = meas.instant_level;
      end
      OP_CNT_QUERY: begin
        if (idx == 4'h2) resp = rcv_cnt[15:8];
        if (idx == 4'h3) resp = rcv_cnt[7:0];
        if (idx == 4'h4) resp = crc_cnt[15:8];
        if (idx == 4'h5) resp = crc_cnt[7:0];
        if (idx == 4'h6) resp = err_cnt[15:8];
        if (idx == 4'h7) resp = err_cnt[7:0];
      end
      default: begin
      end
    endcase
  end

  // frame length check at the rising select edge
  always_comb begin
    unique case (opcode)
      OP_CHIP_STATE: own_ok = idx <= LEN_CHIP_STATE;
      OP_RX_BUF: own_ok = idx <= LEN_RX_BUF;
      OP_PKT_QUAL: own_ok = idx <= LEN_PKT_QUAL;
      OP_INST_LEVEL: own_ok = idx <= LEN_INST_LEVEL;
      OP_CNT_QUERY: own_ok = idx <= LEN_CNT_QUERY;
      OP_CNT_CLEAR: own_ok = idx == LEN_CNT_CLEAR && all_zero;
      default: own_ok = other_opcode_ok;
    endcase
  end

  assign rx_byte = {rx_sh[6:0], mosi_s};

  always_comb begin
    next_state = state;
    next_bitc = bitc;
    next_idx = idx;
    next_rx_sh = rx_sh;
    next_opcode = opcode;
    next_tx_sh = tx_sh;
    next_miso = miso;
    next_all_zero = all_zero;
    next_wdt = wdt;
    next_wdt_hit = 1'b0;
    next_perr = 1'b0;
    next_clr = 1'b0;
    unique case (state)
      SPI_IDLE: begin
        if (cs_fall) begin
          next_state = SPI_XFER;
          next_bitc = 3'h0;
          next_idx = 4'h0;
          next_tx_sh = 8'h00;
          next_miso = 1'b0;
          next_all_zero = 1'b1;
          next_wdt = 32'h0;
        end
      end
      SPI_XFER: begin
        if (wdt < WDT_LIMIT) next_wdt = wdt + 32'h1;
        next_wdt_hit = wdt_en && wdt == WDT_LIMIT - 1;
        if (sck_rise) begin
          next_rx_sh = rx_byte;
          next_bitc = bitc + 3'h1;
          if (bitc == BIT_LAST) begin
            if (idx != IDX_MAX) next_idx = idx + 4'h1;
            if (idx == 4'h0) next_opcode = rx_byte;
            if (rx_byte != 8'h00) next_all_zero = 1'b0;
          end
        end
        if (sck_fall) begin
          if (bitc == 3'h0 && idx != 4'h0) next_tx_sh = resp;
          else next_tx_sh = {tx_sh[6:0], 1'b0};
          next_miso = next_tx_sh[7];
        end
        if (cs_rise) begin
          next_state = SPI_IDLE;
          next_miso = 1'b0;
          next_perr = bitc != 3'h0 || idx == 4'h0 || !own_ok;
          next_clr = bitc == 3'h0 && opcode == OP_CNT_CLEAR && own_ok;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SPI_IDLE;
      bitc <= 3'h0;
      idx <= 4'h0;
      rx_sh <= 8'h00;
      opcode <= 8'h00;
      tx_sh <= 8'h00;
      miso <= 1'b0;
      all_zero <= 1'b0;
      wdt <= 32'h0;
      wdt_hit <= 1'b0;
      perr <= 1'b0;
      clr <= 1'b0;
    end else begin
      state <= next_state;
      bitc <= next_bitc;
      idx <= next_idx;
      rx_sh <= next_rx_sh;
      opcode <= next_opcode;
      tx_sh <= next_tx_sh;
      miso <= next_miso;
      all_zero <= next_all_zero;
      wdt <= next_wdt;
      wdt_hit <= next_wdt_hit;
      perr <= next_perr;
      clr <= next_clr;
    end
  end

  // ==========================================================
  // outcome, measurements, counters
  logic [2:0] next_outcome;
  logic [7:0] next_sync_level, next_payload_level, next_flags, next_pkt_level;
  logic [7:0] next_noise, next_despread, next_rx_len, next_rx_off;
  logic [15:0] next_rcv_cnt, next_crc_cnt, next_err_cnt;
  logic err_evt;
  assign err_evt = chirp_mode ? evt.header_fail : evt.length_fail;

  always_comb begin
    next_outcome = outcome;
    // later lines win: watchdog and decode faults outrank radio events
    if (evt.rx_ok) next_outcome = RES_DATA_AVAIL;
    if (evt.tx_done) next_outcome = RES_TX_DONE;
    if (evt.exec_fail) next_outcome = RES_EXEC_FAIL;
    if (perr) next_outcome = RES_PROC_ERR;
    if (wdt_hit) next_outcome = RES_TIMEOUT;
    next_sync_level = sync_level;
    next_payload_level = payload_level;
    next_flags = flags;
    next_pkt_level = pkt_level;
    next_noise = noise;
    next_despread = despread;
    next_rx_len = rx_len;
    next_rx_off = rx_off;
    if (evt.sync_det && !chirp_mode) next_sync_level = meas.instant_level;
    if (evt.pkt_done) begin
      next_payload_level = meas.payload_mean_level;
      next_flags = meas.receive_flags;
      next_pkt_level = meas.packet_mean_level;
      next_noise = meas.packet_noise_ratio;
      next_despread = meas.despread_signal_level;
      next_rx_len = meas.received_length;
      next_rx_off = meas.received_start_offset;
    end
    // an event in the clearing cycle still counts
    next_rcv_cnt = clr ? 16'h0000 : rcv_cnt;
    next_crc_cnt = clr ? 16'h0000 : crc_cnt;
    next_err_cnt = clr ? 16'h0000 : err_cnt;
    if (evt.rx_ok) next_rcv_cnt = next_rcv_cnt + 16'h0001;
    if (evt.checksum_fail) next_crc_cnt = next_crc_cnt + 16'h0001;
    if (err_evt) next_err_cnt = next_err_cnt + 16'h0001;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outcome <= RES_NONE;
      sync_level <= 8'h00;
      payload_level <= 8'h00;
      flags <= 8'h00;
      pkt_level <= 8'h00;
      noise <= 8'h00;
      despread <= 8'h00;
      rx_len <= 8'h00;
      rx_off <= 8'h00;
      rcv_cnt <= 16'h0000;
      crc_cnt <= 16'h0000;
      err_cnt <= 16'h0000;
    end else begin
      outcome <= next_outcome;
      sync_level <= next_sync_level;
      payload_level <= next_payload_level;
      flags <= next_flags;
      pkt_level <= next_pkt_level;
      noise <= next_noise;
      despread <= next_despread;
      rx_len <= next_rx_len;
      rx_off <= next_rx_off;
      rcv_cnt <= next_rcv_cnt;
      crc_cnt <= next_crc_cnt;
      err_cnt <= next_err_cnt;
    end
  end

  // ==========================================================
  // apb slave: one wait state, unmapped addresses answer with pslverr
  logic next_wdt_en, next_pready, next_pslverr;
  logic [31:0] next_prdata;
  always_comb begin
    next_wdt_en = wdt_en;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    // write lands at the edge where the master samples pready high
    if (psel && penable && pready && pwrite && paddr == REG_CTRL) begin
      next_wdt_en = pwdata[CTRL_WDT_EN];
    end
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      unique case (paddr)
        REG_CTRL: begin
          next_prdata[CTRL_WDT_EN] = wdt_en;
        end
        REG_STATUS: next_prdata[7:0] = status_byte;
        REG_COUNT: next_prdata = {crc_cnt, rcv_cnt};
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_en <= CTRL_WDT_EN_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      wdt_en <= next_wdt_en;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
    end
  end

  // ==========================================================
  // checks
  sequence byte_boundary_s;
    state == SPI_XFER && sck_fall && bitc == 3'h0 && idx == 4'h1;
  endsequence
  sequence clear_frame_s;
    clr && !evt.rx_ok && !evt.checksum_fail && !err_evt;
  endsequence

  AST_STATUS_BYTE1: assert property (@(posedge clk) disable iff (!rst_b)
    byte_boundary_s |=> miso == $past(status_byte[7]) && tx_sh == $past(status_byte))
    else $error("second byte is not the status byte");
  AST_STATUS_LAYOUT: assert property (@(posedge clk) disable iff (!rst_b)
    !status_byte[7] && !status_byte[0] && status_byte[6:4] == chip_mode)
    else $error("status byte layout broken");
  AST_DATA_AVAIL: assert property (@(posedge clk) disable iff (!rst_b)
    outcome == RES_DATA_AVAIL && $changed(outcome) |-> $past(evt.rx_ok))
    else $error("data available without a good packet");
  AST_TX_DONE: assert property (@(posedge clk) disable iff (!rst_b)
    evt.tx_done && !evt.exec_fail && !perr && !wdt_hit |=> outcome == RES_TX_DONE)
    else $error("tx done outcome missing");
  AST_WDT: assert property (@(posedge clk) disable iff (!rst_b)
    state == SPI_XFER && wdt_en && wdt == WDT_LIMIT - 1 |=> ##1 outcome == RES_TIMEOUT)
    else $error("watchdog timeout not flagged");
  AST_PERR: assert property (@(posedge clk) disable iff (!rst_b)
    state == SPI_XFER && cs_rise && bitc != 3'h0 && !(wdt_en && wdt == WDT_LIMIT - 1)
    |=> ##1 outcome == RES_PROC_ERR)
    else $error("partial byte not flagged as processing error");
  AST_CNT_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
    clear_frame_s |=> rcv_cnt == 16'h0 && crc_cnt == 16'h0 && err_cnt == 16'h0)
    else $error("counters not cleared");
  AST_CNT_INC: assert property (@(posedge clk) disable iff (!rst_b)
    evt.rx_ok && !clr |=> rcv_cnt == $past(rcv_cnt) + 16'h1)
    else $error("received counter did not count");
  AST_SYNC_LATCH: assert property (@(posedge clk) disable iff (!rst_b)
    evt.sync_det && !chirp_mode |=> sync_level == $past(meas.instant_level))
    else $error("sync level not latched");
  AST_MISO_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !sck_fall && !cs_rise && state == SPI_XFER |=> $stable(miso))
    else $error("miso changed away from a falling sck edge");
endmodule // rsqr_responder
`default_nettype wire

// [bench/rsqr_host_model.sv]
// host spi master model that drives the command port in mode 0
`default_nettype none
module rsqr_host_model (
  output logic chip_select_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5;
  initial begin
    chip_select_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // ==========================================================
  // one framed transaction; extra_ns stretches it to trip the watchdog
  // tail adds that many loose bits after the whole bytes, cutting the last byte
  task automatic frame(input logic [7:0] tx[16], input int n, input int tail,
    input int extra_ns, output logic [7:0] rx[16]);
    // keeps pin edges off the sampling clock edge
    #1;
    chip_select_n = 1'b0;
    #(HALF);
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        mosi = tx[i][b];
        #(HALF);
        sck = 1'b1;
        rx[i][b] = miso;
        #(HALF);
        sck = 1'b0;
      end
    end
    for (int b = 0; b < tail; b++) begin
      mosi = 1'b1;
      #(HALF);
      sck = 1'b1;
      #(HALF);
      sck = 1'b0;
    end
    #(HALF + extra_ns);
    chip_select_n = 1'b1;
    // no pull on the line, so show the inverse rather than a stale level
    mosi = ~mosi;
    #(200);
  endtask
endmodule // rsqr_host_model
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the radio status query responder
`default_nettype none
module tb_top
  import rsqr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // short watchdog so the stretched frame trips it quickly
  localparam int unsigned WDT = 2000;
  localparam int CNT_BIT [6] = '{5, 5, 5, 4, 4, 3};
  localparam int EV_BIT [3] = '{1, 0, 5};
  localparam logic [2:0] EV_RES [3] = '{RES_TX_DONE, RES_EXEC_FAIL, RES_DATA_AVAIL};
  logic clk = 1'b0;
  logic rst_b, chip_select_n, sck, mosi, miso, chirp_mode, other_opcode_ok;
  logic [2:0] chip_mode;
  rsqr_meas_s meas;
  rsqr_evt_s evt;
  logic psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] tx[16];
  logic [7:0] rx[16];
  int n_mismatch = 0;
  int num_checks = 0;
  always #5 clk = ~clk;
  rsqr_responder #(.WDT_LIMIT(WDT)) DUT (
    .clk(clk), .rst_b(rst_b), .chip_select_n(chip_select_n), .sck(sck), .mosi(mosi),
    .miso(miso), .chip_mode(chip_mode), .chirp_mode(chirp_mode),
    .other_opcode_ok(other_opcode_ok), .meas(meas), .evt(evt), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );
  rsqr_host_model host (
    .chip_select_n(chip_select_n), .sck(sck), .mosi(mosi), .miso(miso)
  );
  // ==========================================================
  // helpers
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] st(input logic [2:0] r);
    return {1'b0, chip_mode, r, 1'b0};
  endfunction
  // entered just after a rising edge; holds the request until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_mismatch++;
      report_and_stop();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic cmd(input logic [7:0] op, input int n, input int extra_ns);
    tx = '{default: 8'h00};
    tx[0] = op;
    host.frame(tx, n, 0, extra_ns, rx);
    @(posedge clk);
  endtask
  task automatic pulse(input int b);
    evt <= rsqr_evt_s'(8'h01 << b);
    @(posedge clk);
    evt <= '0;
    @(posedge clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chip_mode = MODE_STANDBY_RC_OSC_MODE;
    chirp_mode = 1'b0;
    other_opcode_ok = 1'b0;
    meas = '0;
    evt = '0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    apb(1'b0, REG_CTRL, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, {24'h0, st(RES_NONE)});
    apb(1'b0, 8'h0c, 32'h0);
    check(err, 32'h1);
    $display("test registers done");
    for (int m = 2; m <= 6; m++) begin
      chip_mode <= 3'(m);
      @(posedge clk);
      cmd(OP_CHIP_STATE, 2, 0);
      check(rx[1], st(RES_NONE));
    end
    for (int k = 0; k < 3; k++) begin
      pulse(EV_BIT[k]);
      cmd(OP_CHIP_STATE, 2, 0);
      check(rx[1], st(EV_RES[k]));
    end
    $display("test modes and outcomes done");
    meas.received_length <= 8'h2a;
    meas.received_start_offset <= 8'h80;
    pulse(6);
    cmd(OP_RX_BUF, 4, 0);
    check(rx[1], st(RES_DATA_AVAIL));
    check({rx[2], rx[3]}, 32'h2a80);
    meas.instant_level <= 8'h5c;
    cmd(OP_INST_LEVEL, 3, 0);
    check(rx[2], 8'h5c);
    meas.instant_level <= 8'h44;
    meas.receive_flags <= 8'h92;
    pulse(7);
    meas.instant_level <= 8'h55;
    meas.payload_mean_level <= 8'h66;
    pulse(6);
    meas.payload_mean_level <= 8'h77;
    cmd(OP_PKT_QUAL, 5, 0);
    check({rx[2], rx[3], rx[4]}, 32'h924466);
    chirp_mode <= 1'b1;
    meas.packet_mean_level <= 8'h3c;
    meas.packet_noise_ratio <= 8'hf4;
    meas.despread_signal_level <= 8'h48;
    pulse(6);
    cmd(OP_PKT_QUAL, 5, 0);
    check({rx[2], rx[3], rx[4]}, 32'h3cf448);
    chirp_mode <= 1'b0;
    $display("test measurement queries done");
    cmd(OP_CNT_CLEAR, 7, 0);
    for (int k = 0; k < 6; k++) pulse(CNT_BIT[k]);
    // chirp mode: header faults count, length faults do not
    chirp_mode <= 1'b1;
    pulse(2);
    pulse(3);
    chirp_mode <= 1'b0;
    cmd(OP_CNT_CLEAR, 6, 0);
    cmd(OP_CNT_QUERY, 8, 0);
    check(rx[1], st(RES_PROC_ERR));
    check({rx[2], rx[3], rx[4], rx[5]}, 32'h00030002);
    check({rx[6], rx[7]}, 32'h0002);
    apb(1'b0, REG_COUNT, 32'h0);
    check(rd, 32'h00020003);
    cmd(OP_CNT_CLEAR, 7, 0);
    cmd(OP_CNT_QUERY, 8, 0);
    check({rx[2], rx[3], rx[4], rx[5], rx[6], rx[7]}, 32'h0);
    $display("test counters done");
    pulse(1);
    other_opcode_ok <= 1'b1;
    cmd(8'h77, 2, 0);
    other_opcode_ok <= 1'b0;
    cmd(OP_CHIP_STATE, 2, 0);
    check(rx[1], st(RES_TX_DONE));
    tx = '{default: 8'h00};
    tx[0] = OP_CHIP_STATE;
    host.frame(tx, 2, 3, 0, rx);
    @(posedge clk);
    cmd(OP_CHIP_STATE, 2, 0);
    check(rx[1], st(RES_PROC_ERR));
    pulse(1);
    cmd(8'h77, 2, 0);
    cmd(OP_CHIP_STATE, 2, 0);
    check(rx[1], st(RES_PROC_ERR));
    pulse(1);
    apb(1'b1, REG_CTRL, 32'h0);
    cmd(OP_CHIP_STATE, 2, 25000);
    cmd(OP_CHIP_STATE, 2, 0);
    check(rx[1], st(RES_TX_DONE));
    apb(1'b1, REG_CTRL, 32'h1);
    cmd(OP_CHIP_STATE, 2, 25000);
    apb(1'b0, REG_STATUS, 32'h0);
    check(rd, {24'h0, st(RES_TIMEOUT)});
    $display("test errors and watchdog done");
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
